// [rtl/rpc_payload_ctrl.sv]
// Purpose: Receive payload conditioning of one framer: extraction, trunk code, milliwatt,
//          pattern insertion, inversion and signaling override, with an indirect table.
// Assumes: One slot byte per valid beat; mode and alarm inputs synchronous to i_clock.
// Notes:   Outputs are registered one cycle behind the slot beat.
`timescale 1ns/1ps

// Notes on behaviour
// - Per-slot settings act only while the per-channel config enable is set.
// - Pattern select 0 routes the selected framer's data to the detector.
// - E1 unframed extraction sends all 32 slots, ignoring per-slot flags.
// - Framed extraction sends only slots whose test flag is set.
// - T1 unframed extraction sends all 24 channels plus framing bit.
// - T1 fractional extract takes the Nx56k part of a flagged channel.
// - Data trunk flag replaces the slot byte with its trunk code.
// - Auto-on-frame-loss replaces every slot with trunk code while out of sync.
// - E1 auto-on-red replaces all slots after 100 ms out of sync.
// - T1 auto-on-red replaces all channels while red alarm is declared.
// - Automatic replacements ignore the config enable and cover every slot.
// - Milliwatt flag outputs milliwatt; E1 picks A or mu law, T1 mu only.
// - A-law milliwatt repeats its eight fixed bytes.
// - Mu-law milliwatt repeats its eight fixed bytes.
// - Pattern select 1 inserts generator data in flagged or all slots.
// - T1 unframed insertion replaces all; fractional insert replaces Nx56k part.
// - E1 per-slot bits invert the MSB, even bits and odd bits.
// - T1 per-channel bits invert the MSB and the other seven bits.
// - T1 fix bit forces the channel signaling to the fixed value.
// - Conditioning priority: extraction, trunk, milliwatt, insertion, inversion, fix.
// - Signaling trunk flag outputs the stored ABCD nibble.
// - Indirect access holds busy 490 ns E1 or 650 ns T1; wait for clear.
module rpc_payload_ctrl
  import rpc_pkg::*;
#(
  parameter int RED_CYC = RPC_RED_CYC
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire rpc_apb_req_t i_apb,
  output rpc_apb_rsp_t      o_apb,
  input  wire logic         i_t1_mode,
  input  wire logic [2:0]   i_framer_id,
  input  wire logic         i_sync_lost,
  input  wire logic         i_red_alarm,
  input  wire logic [7:0]   i_prbs_gen,
  input  wire rpc_rx_t      i_rx,
  output rpc_sys_t          o_sys,
  output rpc_det_t          o_det
);

  // ---------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------
  rpc_state_t s;
  rpc_state_t next_s;

  logic       setup;
  logic       wr;
  logic       hit;
  logic [7:0] idx;
  logic [7:0] rd_byte;
  logic       start_ok;
  logic       t1;

  // APB phases; the access phase is always one cycle since pready follows setup.
  assign setup    = i_apb.psel & ~i_apb.penable;
  assign wr       = i_apb.psel & i_apb.penable & s.apb.pready & ~s.apb.pslverr & i_apb.pwrite;
  assign idx      = i_apb.paddr[9:2];
  assign hit      = (i_apb.paddr[1:0] == 2'b00) && (idx inside {RPC_IDX_AUTO, RPC_IDX_MTRK,
                    RPC_IDX_E1_ROUTE, RPC_IDX_T1_ROUTE, RPC_IDX_T1_CFG, RPC_IDX_T1_STAT,
                    RPC_IDX_T1_ACMD, RPC_IDX_T1_DATA, RPC_IDX_E1_CFG, RPC_IDX_E1_STAT,
                    RPC_IDX_E1_ACMD, RPC_IDX_E1_DATA});
  assign start_ok = wr && (idx == RPC_IDX_E1_ACMD || idx == RPC_IDX_T1_ACMD) && s.ind == RPC_IDLE;
  assign t1       = i_t1_mode;

  // ---------------------------------------------------------------
  // Slot lookup and conditioning flags
  // ---------------------------------------------------------------
  logic [6:0] ctl_a;
  logic [6:0] trk_a;
  logic [6:0] sig_a;
  logic [7:0] ctl;
  logic [7:0] trk;
  logic [7:0] sgb;
  logic       chan;
  logic       per;
  logic       test;
  logic       dtrk;
  logic       milliwatt_en;
  logic       alaw;
  logic       red;
  logic       auto_on;
  logic       mtrk_on;
  logic       mine;
  logic       extract;
  logic       insert;
  logic       strk;
  logic       fix;
  logic [7:0] emask;
  logic [7:0] imask;
  logic [7:0] inv_mask;
  logic [7:0] mw_byte;

  // Table entries of the slot now arriving.
  assign ctl_a = t1 ? 7'(RPC_T1_CTL_BASE + 7'(i_rx.slot)) : 7'(RPC_E1_CTL_BASE + 7'(i_rx.slot));
  assign trk_a = t1 ? 7'(RPC_T1_TRK_BASE + 7'(i_rx.slot)) : 7'(RPC_E1_TRK_BASE + 7'(i_rx.slot));
  assign sig_a = t1 ? 7'(RPC_T1_SIG_BASE + 7'(i_rx.slot)) : 7'(RPC_E1_SIG_BASE + 7'(i_rx.slot));
  assign ctl   = s.mem[ctl_a];
  assign trk   = s.mem[trk_a];
  assign sgb   = s.mem[sig_a];

  // The T1 framing bit is no channel, so per-slot flags never touch it.
  assign chan = ~(t1 & i_rx.fbit);
  assign per  = s.cfg[RPC_PER_CHANNEL_CONFIG_ENABLE_BIT] & chan;
  assign test = per & (t1 ? ctl[RPC_T1_TEST] : ctl[RPC_E1_TEST]);
  assign dtrk = per & ctl[RPC_E1_DTRK];
  assign milliwatt_en  = per & (t1 ? ctl[RPC_T1_DMW] : ctl[RPC_E1_DMW]);
  assign alaw = ~t1 & ctl[RPC_E1_LAW];
  assign strk = per & (t1 ? sgb[RPC_T1_STRK] : ctl[RPC_E1_STRK]);
  assign fix  = per & t1 & ctl[RPC_T1_FIX];

  // Red condition: T1 follows the alarm, E1 waits out the loss timer.
  assign red     = t1 ? i_red_alarm : (s.red_cnt == 22'(RED_CYC));
  // Automatic trunk conditioning ignores the enable bit.
  assign auto_on = chan & ((s.auto_ctl[RPC_AUTO_OOF_BIT] & i_sync_lost) |
                           (s.auto_ctl[RPC_AUTO_RED_BIT] & red));
  assign mtrk_on = per & s.mtrk[RPC_MTRK_BIT];

  // Shared pattern engine serves the framer named by the route selector.
  assign mine    = s.route[7:RPC_SEL_LSB] == i_framer_id;
  assign extract = mine & ~s.route[RPC_PATSEL_BIT] & (s.route[RPC_UNFRAMED_EXTRACT_BIT] | test);
  assign insert  = mine & s.route[RPC_PATSEL_BIT] & (s.route[RPC_UNFRAMED_INSERT_BIT] | test);
  assign emask   = (t1 & s.route[RPC_FRAC_DET_BIT] & ~s.route[RPC_UNFRAMED_EXTRACT_BIT]) ?
                   RPC_FRAC_MASK : RPC_FULL_MASK;
  assign imask   = (t1 & s.route[RPC_FRAC_GEN_BIT] & ~s.route[RPC_UNFRAMED_INSERT_BIT]) ?
                   RPC_FRAC_MASK : RPC_FULL_MASK;

  // Inversion pattern per mode.
  always_comb begin
    inv_mask = 8'h00;
    if (t1) begin
      if (per & ctl[RPC_T1_SINV]) inv_mask = inv_mask | RPC_MSB_MASK;
      if (per & ctl[RPC_T1_INV]) inv_mask = inv_mask | RPC_REST_MASK;
    end else begin
      if (per & ctl[RPC_E1_SINV]) inv_mask = inv_mask | RPC_MSB_MASK;
      if (per & ctl[RPC_E1_EVEN]) inv_mask = inv_mask | RPC_EVEN_MASK;
      if (per & ctl[RPC_E1_ODD]) inv_mask = inv_mask | RPC_ODD_MASK;
    end
  end

  // Milliwatt byte for the current frame phase.
  assign mw_byte = alaw ? RPC_MW_ALAW[s.mw_phase] : RPC_MW_MULAW[s.mw_phase];

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  always_comb begin
    unique case (idx)
      RPC_IDX_AUTO:                      rd_byte = s.auto_ctl;
      RPC_IDX_MTRK:                      rd_byte = s.mtrk;
      RPC_IDX_E1_ROUTE, RPC_IDX_T1_ROUTE: rd_byte = s.route;
      RPC_IDX_E1_CFG, RPC_IDX_T1_CFG:     rd_byte = s.cfg;
      RPC_IDX_E1_STAT, RPC_IDX_T1_STAT:   rd_byte = {s.ind == RPC_BUSY, 7'h00};
      RPC_IDX_E1_ACMD, RPC_IDX_T1_ACMD:   rd_byte = {s.ind_rnw, s.ind_addr};
      RPC_IDX_E1_DATA, RPC_IDX_T1_DATA:   rd_byte = s.ind_data;
      default:                           rd_byte = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Zero-wait answer: registered in setup, shown during the access phase.
    next_s.apb.pready  = setup;
    next_s.apb.pslverr = setup & ~hit;
    next_s.apb.prdata  = (setup & ~i_apb.pwrite & hit) ? {24'h000000, rd_byte} : 32'h00000000;

    // Software writes to direct registers.
    if (wr) begin
      unique case (idx)
        RPC_IDX_AUTO:                       next_s.auto_ctl = i_apb.pwdata[7:0];
        RPC_IDX_MTRK:                       next_s.mtrk = i_apb.pwdata[7:0];
        RPC_IDX_E1_ROUTE, RPC_IDX_T1_ROUTE: next_s.route = i_apb.pwdata[7:0];
        RPC_IDX_E1_CFG, RPC_IDX_T1_CFG:     next_s.cfg = i_apb.pwdata[7:0];
        RPC_IDX_E1_DATA, RPC_IDX_T1_DATA:   next_s.ind_data = i_apb.pwdata[7:0];
        default:                            next_s.cfg = s.cfg;
      endcase
    end

    // Indirect access start; a request while busy is dropped.
    if (start_ok) begin
      next_s.ind      = RPC_BUSY;
      next_s.ind_rnw  = i_apb.pwdata[RPC_RNW_BIT];
      next_s.ind_addr = i_apb.pwdata[6:0];
      next_s.busy_cnt = t1 ? 5'(RPC_T1_BUSY_CYC - 1) : 5'(RPC_E1_BUSY_CYC - 1);
      if (!i_apb.pwdata[RPC_RNW_BIT]) begin
        next_s.mem[i_apb.pwdata[6:0]] = s.ind_data;
      end
    end

    // Busy countdown; read data lands as busy drops and wins over a data write.
    if (s.ind == RPC_BUSY) begin
      if (s.busy_cnt == 5'h00) begin
        next_s.ind = RPC_IDLE;
        if (s.ind_rnw) begin
          next_s.ind_data = s.mem[s.ind_addr];
        end
      end else begin
        next_s.busy_cnt = s.busy_cnt - 5'h01;
      end
    end

    // E1 loss-of-frame timer, saturating at the red threshold.
    if (!t1 && i_sync_lost) begin
      if (s.red_cnt != 22'(RED_CYC)) begin
        next_s.red_cnt = s.red_cnt + 22'h000001;
      end
    end else begin
      next_s.red_cnt = 22'h000000;
    end

    // Milliwatt phase steps once per frame.
    if (i_rx.valid && chan && i_rx.slot == 5'h00) begin
      next_s.mw_phase = s.mw_phase + 3'h1;
    end

    // Detector tap sees the received byte before any replacement.
    next_s.det.valid = i_rx.valid & extract;
    next_s.det.data  = i_rx.data;
    next_s.det.mask  = extract ? emask : 8'h00;

    // Data path in fixed priority order.
    next_s.sys.valid = i_rx.valid;
    if (dtrk | auto_on | mtrk_on) begin
      next_s.sys.data = trk;
    end else if (milliwatt_en) begin
      next_s.sys.data = mw_byte;
    end else if (insert) begin
      next_s.sys.data = (i_prbs_gen & imask) | (i_rx.data & ~imask);
    end else begin
      next_s.sys.data = i_rx.data ^ inv_mask;
    end

    // Signaling path.
    if (mtrk_on | strk) begin
      next_s.sys.sig = sgb[3:0];
    end else if (fix) begin
      next_s.sys.sig = {4{ctl[RPC_T1_VAL]}};
    end else begin
      next_s.sys.sig = i_rx.sig;
    end
  end

  // State register.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_apb = s.apb;
  assign o_sys = s.sys;
  assign o_det = s.det;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  // Busy is checked for the first eight cycles and at the twelfth, and must clear 13 to 17 cycles after it rises.
  busy_hold_a: assert property ($rose(s.ind == RPC_BUSY) |-> (s.ind == RPC_BUSY)[*8] ##4 (s.ind == RPC_BUSY))
    else $error("busy dropped early");
  busy_end_a: assert property ($rose(s.ind == RPC_BUSY) |-> ##[13:17] (s.ind == RPC_IDLE))
    else $error("busy never cleared");
  ind_write_a: assert property (start_ok && !i_apb.pwdata[RPC_RNW_BIT] |=>
    s.mem[$past(i_apb.pwdata[6:0])] == $past(s.ind_data))
    else $error("indirect write lost");
  trunk_out_a: assert property (i_rx.valid && dtrk |=> o_sys.valid && o_sys.data == $past(trk))
    else $error("trunk code not output");
  auto_oof_a: assert property (i_rx.valid && chan && s.auto_ctl[RPC_AUTO_OOF_BIT] && i_sync_lost
    |=> o_sys.data == $past(trk))
    else $error("auto trunk missing");
  mw_mulaw_a: assert property (i_rx.valid && t1 && milliwatt_en && !dtrk && !auto_on && !mtrk_on
    |=> o_sys.data == RPC_MW_MULAW[$past(s.mw_phase)])
    else $error("mu-law milliwatt wrong");
  unf_extract_a: assert property (i_rx.valid && mine && !s.route[RPC_PATSEL_BIT]
    && s.route[RPC_UNFRAMED_EXTRACT_BIT] |=> o_det.valid && o_det.mask == RPC_FULL_MASK && o_det.data == $past(i_rx.data))
    else $error("unframed extraction missed");
  unf_insert_a: assert property (i_rx.valid && mine && s.route[RPC_PATSEL_BIT] && s.route[RPC_UNFRAMED_INSERT_BIT]
    && imask == RPC_FULL_MASK && !dtrk && !auto_on && !mtrk_on && !milliwatt_en |=> o_sys.data == $past(i_prbs_gen))
    else $error("pattern not inserted");
  sig_fix_a: assert property (i_rx.valid && fix && !strk && !mtrk_on |=> o_sys.sig == {4{$past(ctl[RPC_T1_VAL])}})
    else $error("signaling not fixed");
  no_enable_a: assert property (i_rx.valid && !s.cfg[RPC_PER_CHANNEL_CONFIG_ENABLE_BIT] && !auto_on && !insert
    |=> o_sys.data == $past(i_rx.data))
    else $error("per-slot setting acted while disabled");

  ind_read_c: cover property (start_ok && i_apb.pwdata[RPC_RNW_BIT] ##[13:17] s.ind == RPC_IDLE);
  auto_red_c: cover property (!t1 && red && s.auto_ctl[RPC_AUTO_RED_BIT] && i_rx.valid);
  alaw_mw_c: cover property (i_rx.valid && milliwatt_en && alaw);
  frac_det_c: cover property (o_det.valid && o_det.mask == RPC_FRAC_MASK);

endmodule

// [pkg/rpc_pkg.sv]
// Purpose: Shared constants and carrier types for the receive payload control stage.
// Assumes: 25 MHz clock; registers reached over APB, one word per register index.
// Notes:   Byte address of a register is four times its index.
package rpc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int RPC_CLK_PS      = 40000;
  localparam int RPC_E1_BUSY_NS  = 490;
  localparam int RPC_T1_BUSY_NS  = 650;
  localparam int RPC_E1_BUSY_CYC = (RPC_E1_BUSY_NS * 1000 + RPC_CLK_PS - 1) / RPC_CLK_PS;
  localparam int RPC_T1_BUSY_CYC = (RPC_T1_BUSY_NS * 1000 + RPC_CLK_PS - 1) / RPC_CLK_PS;
  localparam int RPC_RED_MS      = 100;
  localparam int RPC_RED_CYC     = RPC_RED_MS * (1000000000 / RPC_CLK_PS);

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] RPC_IDX_AUTO     = 8'h00;
  localparam logic [7:0] RPC_IDX_MTRK     = 8'h01;
  localparam logic [7:0] RPC_IDX_E1_ROUTE = 8'h0C;
  localparam logic [7:0] RPC_IDX_T1_ROUTE = 8'h0F;
  localparam logic [7:0] RPC_IDX_T1_CFG   = 8'h50;
  localparam logic [7:0] RPC_IDX_T1_STAT  = 8'h51;
  localparam logic [7:0] RPC_IDX_T1_ACMD  = 8'h52;
  localparam logic [7:0] RPC_IDX_T1_DATA  = 8'h53;
  localparam logic [7:0] RPC_IDX_E1_CFG   = 8'h5C;
  localparam logic [7:0] RPC_IDX_E1_STAT  = 8'h5D;
  localparam logic [7:0] RPC_IDX_E1_ACMD  = 8'h5E;
  localparam logic [7:0] RPC_IDX_E1_DATA  = 8'h5F;
  localparam logic [7:0] RPC_REG_RESET    = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int RPC_AUTO_OOF_BIT = 1;
  localparam int RPC_AUTO_RED_BIT = 2;
  localparam int RPC_MTRK_BIT     = 0;
  localparam int RPC_PER_CHANNEL_CONFIG_ENABLE_BIT     = 0;
  localparam int RPC_BUSY_BIT     = 7;
  localparam int RPC_RNW_BIT      = 7;
  localparam int RPC_SEL_LSB      = 5;
  localparam int RPC_PATSEL_BIT   = 2;
  localparam int RPC_UNFRAMED_EXTRACT_BIT  = 0;
  localparam int RPC_UNFRAMED_INSERT_BIT  = 1;
  localparam int RPC_FRAC_DET_BIT = 3;
  localparam int RPC_FRAC_GEN_BIT = 4;
  // Per-slot control byte, E1 layout.
  localparam int RPC_E1_TEST = 7;
  localparam int RPC_E1_DTRK = 6;
  localparam int RPC_E1_STRK = 5;
  localparam int RPC_E1_DMW  = 4;
  localparam int RPC_E1_LAW  = 3;
  localparam int RPC_E1_SINV = 2;
  localparam int RPC_E1_EVEN = 1;
  localparam int RPC_E1_ODD  = 0;
  // Per-channel control byte, T1/J1 layout; RPC_T1_STRK is a bit of the signaling byte.
  localparam int RPC_T1_INV  = 7;
  localparam int RPC_T1_DTRK = 6;
  localparam int RPC_T1_DMW  = 5;
  localparam int RPC_T1_SINV = 4;
  localparam int RPC_T1_TEST = 3;
  localparam int RPC_T1_FIX  = 1;
  localparam int RPC_T1_VAL  = 0;
  localparam int RPC_T1_STRK = 7;

  // Indirect table bases.
  localparam logic [6:0] RPC_E1_CTL_BASE = 7'h20;
  localparam logic [6:0] RPC_E1_TRK_BASE = 7'h40;
  localparam logic [6:0] RPC_E1_SIG_BASE = 7'h60;
  localparam logic [6:0] RPC_T1_CTL_BASE = 7'h01;
  localparam logic [6:0] RPC_T1_TRK_BASE = 7'h19;
  localparam logic [6:0] RPC_T1_SIG_BASE = 7'h31;

  // Bit masks; byte bit 7 is the first bit on the line.
  localparam logic [7:0] RPC_MSB_MASK  = 8'h80;
  localparam logic [7:0] RPC_REST_MASK = 8'h7F;
  localparam logic [7:0] RPC_EVEN_MASK = 8'hAA;
  localparam logic [7:0] RPC_ODD_MASK  = 8'h55;
  localparam logic [7:0] RPC_FRAC_MASK = 8'hFE;
  localparam logic [7:0] RPC_FULL_MASK = 8'hFF;

  // Milliwatt sequences.
  localparam logic [0:7][7:0] RPC_MW_ALAW = {8'h34, 8'h21, 8'h21, 8'h34, 8'hB4, 8'hA1, 8'hA1, 8'hB4};
  localparam logic [0:7][7:0] RPC_MW_MULAW = {8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {RPC_IDLE, RPC_BUSY} rpc_ind_st_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
  } rpc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rpc_apb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic       fbit;
    logic [4:0] slot;
    logic [7:0] data;
    logic [3:0] sig;
  } rpc_rx_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [3:0] sig;
  } rpc_sys_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [7:0] mask;
  } rpc_det_t;

  typedef struct packed {
    rpc_ind_st_t     ind;
    logic [4:0]      busy_cnt;
    logic [6:0]      ind_addr;
    logic            ind_rnw;
    logic [7:0]      ind_data;
    logic [7:0]      auto_ctl;
    logic [7:0]      mtrk;
    logic [7:0]      route;
    logic [7:0]      cfg;
    logic [21:0]     red_cnt;
    logic [2:0]      mw_phase;
    rpc_apb_rsp_t    apb;
    rpc_sys_t        sys;
    rpc_det_t        det;
    logic [127:0][7:0] mem;
  } rpc_state_t;

endpackage

// [verification/rpc_sys_sink.sv]
// Purpose: Backplane receive side that takes each conditioned slot beat.
// Assumes: Beats arrive as one-cycle valid pulses on the system port.
// Notes:   Keeps the last beat and a running count for the bench.
`timescale 1ns/1ps
module rpc_sys_sink
  import rpc_pkg::*;
(
  input  wire logic     i_clock,
  input  wire logic     i_rst,
  input  wire rpc_sys_t i_sys,
  output rpc_sys_t      o_last,
  output logic [15:0]   o_count
);
  // Capture every valid beat; a lost or doubled pulse shows up in the count.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_last  <= '0;
      o_count <= 16'h0000;
    end else if (i_sys.valid) begin
      o_last  <= i_sys;
      o_count <= o_count + 16'h0001;
    end
  end
endmodule

// [verification/rx_payload_control_bench.sv]
// Purpose: Self-checking bench for the receive payload control stage.
// Assumes: APB access phase of one cycle; outputs one cycle after each slot beat.
// Notes:   The red alarm delay is shortened to RED cycles.
`timescale 1ns/1ps
module rx_payload_control_bench;
  import rpc_pkg::*;
  localparam int RED = 20;
  logic         i_clock = 1'b0;
  logic         i_rst   = 1'b1;
  rpc_apb_req_t req     = '0;
  rpc_apb_rsp_t rsp;
  logic         t1      = 1'b0;
  logic         lost    = 1'b0;
  logic         red     = 1'b0;
  logic [7:0]   gen     = 8'h3C;
  rpc_rx_t      rx      = '0;
  rpc_sys_t     sys;
  rpc_det_t     det;
  rpc_sys_t     last;
  logic [15:0]  count;
  int           failures = 0;
  int           samples_checked = 0;
  logic [7:0]   mw [0:1][0:7] = '{'{8'h34, 8'h21, 8'h21, 8'h34, 8'hB4, 8'hA1, 8'hA1, 8'hB4},
                                  '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E}};

  // Clock of 40 ns.
  always #20 i_clock = ~i_clock;

  rpc_payload_ctrl #(.RED_CYC(RED)) dut (.i_clock(i_clock), .i_rst(i_rst), .i_apb(req), .o_apb(rsp),
    .i_t1_mode(t1), .i_framer_id(3'h0), .i_sync_lost(lost), .i_red_alarm(red), .i_prbs_gen(gen),
    .i_rx(rx), .o_sys(sys), .o_det(det));
  rpc_sys_sink sink (.i_clock(i_clock), .i_rst(i_rst), .i_sys(sys), .o_last(last), .o_count(count));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge i_clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: {24'h0, d}};
    @(posedge i_clock);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    // A transfer that never completes counts as a mismatch.
    if (rsp.pready !== 1'b1) failures++;
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(r, {24'h0, exp});
  endtask

  // Indirect access through the port of the current mode; a read compares with d.
  task automatic ind(input logic rnw, input logic [6:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    int          n;
    if (!rnw) wr(t1 ? RPC_IDX_T1_DATA : RPC_IDX_E1_DATA, d);
    wr(t1 ? RPC_IDX_T1_ACMD : RPC_IDX_E1_ACMD, {rnw, a});
    n = 0;
    do begin
      apb(1'b0, t1 ? RPC_IDX_T1_STAT : RPC_IDX_E1_STAT, 8'h00, r, e);
      n++;
    end while (r[7] === 1'b1 && n < 20);
    // Busy that never clears counts as a mismatch.
    if (r[7] !== 1'b0) failures++;
    chk({31'h0, n > 1}, 32'h1);
    if (rnw) rd(t1 ? RPC_IDX_T1_DATA : RPC_IDX_E1_DATA, d);
  endtask

  // One slot beat, then the detector tap and the backplane capture are compared.
  task automatic beat(input logic [4:0] s, input logic [7:0] d, input logic [3:0] g,
                      input logic [7:0] ed, input logic [3:0] eg, input logic ev);
    logic [15:0] c0;
    c0 = count;
    @(posedge i_clock);
    rx <= '{valid: 1'b1, fbit: 1'b0, slot: s, data: d, sig: g};
    @(posedge i_clock);
    rx.valid <= 1'b0;
    @(posedge i_clock);
    chk({31'h0, det.valid}, {31'h0, ev});
    if (ev) chk({24'h0, det.data}, {24'h0, d});
    @(posedge i_clock);
    chk({20'h0, last.data, last.sig}, {20'h0, ed, eg});
    chk({16'h0, count}, {16'h0, c0 + 16'h0001});
  endtask

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  // Watchdog cuts a hang short.
  initial begin
    #2000000;
    failures++;
    close_out();
  end

  // Main sequence.
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(RPC_IDX_E1_CFG, 8'h00);
    wr(RPC_IDX_E1_CFG, 8'h01);
    rd(RPC_IDX_T1_CFG, 8'h01);
    apb(1'b0, 8'h7F, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    ind(1'b0, 7'h20, 8'h18);
    for (int k = 0; k < 16; k++) begin
      if (k == 8) ind(1'b0, 7'h20, 8'h10);
      beat(5'd0, 8'h55, 4'h0, mw[k / 8][k % 8], 4'h0, 1'b0);
    end
    ind(1'b0, 7'h43, 8'h5A);
    ind(1'b0, 7'h63, 8'h09);
    ind(1'b0, 7'h23, 8'hF0);
    ind(1'b1, 7'h43, 8'h5A);
    beat(5'd3, 8'h11, 4'h2, 8'h5A, 4'h9, 1'b1);
    wr(RPC_IDX_E1_CFG, 8'h00);
    beat(5'd3, 8'h11, 4'h2, 8'h11, 4'h2, 1'b0);
    lost <= 1'b1;
    wr(RPC_IDX_AUTO, 8'h02);
    beat(5'd3, 8'h11, 4'h2, 8'h5A, 4'h2, 1'b0);
    beat(5'd4, 8'h11, 4'h2, 8'h00, 4'h2, 1'b0);
    lost <= 1'b0;
    wr(RPC_IDX_AUTO, 8'h04);
    lost <= 1'b1;
    beat(5'd3, 8'h11, 4'h2, 8'h11, 4'h2, 1'b0);
    repeat (RED) @(posedge i_clock);
    beat(5'd3, 8'h11, 4'h2, 8'h5A, 4'h2, 1'b0);
    lost <= 1'b0;
    wr(RPC_IDX_AUTO, 8'h00);
    wr(RPC_IDX_E1_CFG, 8'h01);
    ind(1'b0, 7'h23, 8'h84);
    wr(RPC_IDX_E1_ROUTE, 8'h04);
    beat(5'd3, 8'h11, 4'h2, 8'h3C, 4'h2, 1'b0);
    wr(RPC_IDX_E1_ROUTE, 8'h00);
    beat(5'd3, 8'h11, 4'h2, 8'h91, 4'h2, 1'b1);
    ind(1'b0, 7'h23, 8'h83);
    beat(5'd3, 8'h11, 4'h2, 8'hEE, 4'h2, 1'b1);
    wr(RPC_IDX_E1_ROUTE, 8'h01);
    beat(5'd5, 8'h22, 4'h1, 8'h22, 4'h1, 1'b1);
    wr(RPC_IDX_E1_ROUTE, 8'h20);
    beat(5'd3, 8'h11, 4'h2, 8'hEE, 4'h2, 1'b0);
    t1 <= 1'b1;
    red <= 1'b1;
    wr(RPC_IDX_AUTO, 8'h04);
    ind(1'b0, 7'h19, 8'hC3);
    beat(5'd0, 8'h11, 4'h5, 8'hC3, 4'h5, 1'b0);
    red <= 1'b0;
    ind(1'b0, 7'h01, 8'h03);
    beat(5'd0, 8'h11, 4'h5, 8'h11, 4'hF, 1'b0);
    wr(RPC_IDX_MTRK, 8'h01);
    beat(5'd0, 8'h11, 4'h5, 8'hC3, 4'h0, 1'b0);
    wr(RPC_IDX_MTRK, 8'h00);
    ind(1'b0, 7'h01, 8'h20);
    beat(5'd0, 8'h11, 4'h5, mw[1][3], 4'h5, 1'b0);
    wr(RPC_IDX_T1_ROUTE, 8'h06);
    beat(5'd1, 8'h11, 4'h5, 8'h3C, 4'h5, 1'b0);
    close_out();
  end
endmodule
